// ### rac_params.svh
// Constants for the register access cell bank: indices, masks, reset values.
// Assumes it is included by bare name from the design files.
//
// Functional notes
// - Read/write bits store and return written value.
// - Read-only bits ignore writes, show current value.
// - Write-only bits accept writes, read value undefined.
// - Reserved bits always read back as zero.
// - Read-only fields never show reserved encodings.
// - Power and software reset restore reset values.
// - Debug register survives peripheral software reset.
// - One to clear alias clears shared bit.
// - One to set alias sets shared bit.
// - Both aliases read the same shared value.
// - Simultaneous set and clear: clear wins.
`ifndef RAC_PARAMS_SVH
`define RAC_PARAMS_SVH

`define RAC_IDX_CTRL 3'h0
`define RAC_IDX_STATUS 3'h1
`define RAC_IDX_CMD 3'h2
`define RAC_IDX_FLAGSET 3'h3
`define RAC_IDX_FLAGCLR 3'h4
`define RAC_IDX_DEBUG 3'h5

`define RAC_CTRL_RSVD 8'hc0
`define RAC_DEBUG_RSVD 8'hf0
`define RAC_CTRL_RST 8'h00
`define RAC_DEBUG_RST 8'h00
`define RAC_STATUS_RST 8'h00
`define RAC_FLAGS_RST 8'h00
`define RAC_CMD_RST 8'h00
`define RAC_RDATA_RST 8'h00

`define RAC_STATE_LSB 0
`define RAC_STATE_MSB 1
`define RAC_STATE_RSVD 2'h3

`endif

// ### rac_pkg.sv
// Types shared by the register access cell bank.
// Assumes nothing of its surroundings.
package rac_pkg;
   typedef logic [7:0] rac_byte_t;
   typedef logic [2:0] rac_idx_t;
endpackage

// ### rac_setclr_if.sv
// Carrier between the bank and its set/clear pair cell.
// Assumes one clock domain on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface rac_setclr_if #(parameter int DW = 8);
   logic [DW-1:0] setMask;
   logic [DW-1:0] clrMask;
   logic softRst;
   logic [DW-1:0] value;
   modport owner (input setMask, input clrMask, input softRst, output value);
   modport user (output setMask, output clrMask, output softRst, input value);
endinterface
`default_nettype wire

// ### rac_setclr.sv
// Shared storage behind a set alias and a clear alias.
// Assumes masks are already gated by their write strobes.
`timescale 1ns/1ps
`default_nettype none
`include "rac_params.svh"
module rac_setclr #(
   parameter int DW = 8
) (
   input wire logic clk_sys, // System clock
   input wire logic rst, // Synchronous reset, active high
   rac_setclr_if.owner sc // Masks in, shared value out
);
   logic [DW-1:0] value_r;
   logic [DW-1:0] value_nxt;

   // Shared storage is read through one byte at most
   if (DW < 1 || DW > 8) begin : g_bad_dw
      $error("rac_setclr: DW must be 1 to 8");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clear applied after set so a bit asked in both ends cleared
   always_comb begin
      value_nxt = (value_r | sc.setMask) & ~sc.clrMask;
   end

   always_ff @(posedge clk_sys) begin
      if (rst || sc.softRst) begin
         value_r <= DW'(`RAC_FLAGS_RST);
      end else begin
         value_r <= value_nxt;
      end
   end

   assign sc.value = value_r;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst || sc.softRst);

   sequence clrReq;
      (sc.clrMask != '0);
   endsequence

   a_clear_bits: assert property (clrReq |=> ((value_r & $past(sc.clrMask)) == '0))
      else $error("cleared bit still set");
   a_set_bits: assert property ((sc.setMask != '0) |=>
      ((value_r & ($past(sc.setMask) & ~$past(sc.clrMask))) ==
       ($past(sc.setMask) & ~$past(sc.clrMask))))
      else $error("set bit not set");
   a_clear_wins: assert property (((sc.setMask & sc.clrMask) != '0) ##1 1'b1 |->
      ((value_r & $past(sc.setMask) & $past(sc.clrMask)) == '0))
      else $error("set beat clear");
   a_zero_keeps: assert property (((sc.setMask | sc.clrMask) == '0) |=> $stable(value_r))
      else $error("value moved without request");
endmodule
`default_nettype wire

// ### rac_bank.sv
// Register access cell bank: one cell of each access kind.
// Assumes synchronous strobes on clk_sys; reads answer one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "rac_params.svh"
module rac_bank #(
   parameter int DW = 8
) (
   input wire logic clk_sys, // System clock, 50 MHz
   input wire logic rst, // Power reset, synchronous, active high
   input wire logic softRst, // Peripheral software reset pulse
   input wire logic wrEn, // Write strobe
   input wire rac_pkg::rac_idx_t wrSel, // Written register index
   input wire rac_pkg::rac_byte_t wrData, // Write data
   input wire logic setEn, // Extra set alias strobe
   input wire logic [DW-1:0] setData, // Extra set alias data
   input wire logic clrEn, // Extra clear alias strobe
   input wire logic [DW-1:0] clrData, // Extra clear alias data
   input wire rac_pkg::rac_byte_t statusIn, // Live status for read-only cell
   input wire rac_pkg::rac_idx_t rdSel, // Read register index
   output rac_pkg::rac_byte_t rdData_r, // Read data, one cycle after rdSel
   output rac_pkg::rac_byte_t ctrlOut_r, // Read/write cell contents
   output rac_pkg::rac_byte_t cmdOut_r, // Last write-only value
   output logic cmdPulse_r, // One cycle after a write-only write
   output rac_pkg::rac_byte_t dbgOut_r, // Debug cell contents
   output logic [DW-1:0] flagsOut_r // Shared set/clear storage
);
   rac_pkg::rac_byte_t status_r;
   rac_pkg::rac_byte_t statusClean;
   rac_pkg::rac_byte_t flagsWide;
   rac_pkg::rac_byte_t rdData_nxt;
   logic anyRst;
   logic [DW-1:0] setMask;
   logic [DW-1:0] clrMask;

   rac_setclr_if #(.DW(DW)) sc ();

   // Flags are zero-extended into a byte-wide read path
   if (DW < 1 || DW > 8) begin : g_bad_dw
      $error("rac_bank: DW must be 1 to 8");
   end

   function automatic rac_pkg::rac_byte_t keepLegal(input rac_pkg::rac_byte_t d,
                                                    input rac_pkg::rac_byte_t rsvd);
      keepLegal = d & ~rsvd;
   endfunction

   function automatic logic hit(input logic en, input rac_pkg::rac_idx_t sel,
                                input rac_pkg::rac_idx_t idx);
      hit = en && (sel == idx);
   endfunction

   assign anyRst = rst || softRst;

   ////////////////////////////////////////////////////////////////////////////
   // Read/write cell
   always_ff @(posedge clk_sys) begin
      if (anyRst) begin
         ctrlOut_r <= `RAC_CTRL_RST;
      end else if (hit(wrEn, wrSel, `RAC_IDX_CTRL)) begin
         ctrlOut_r <= keepLegal(wrData, `RAC_CTRL_RSVD);
      end
   end

   // Debug cell: only power reset touches it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dbgOut_r <= `RAC_DEBUG_RST;
      end else if (hit(wrEn, wrSel, `RAC_IDX_DEBUG)) begin
         dbgOut_r <= keepLegal(wrData, `RAC_DEBUG_RSVD);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read-only cell; a reserved state code holds the last legal one,
   // trading a stale state code for as long as the reserved code lasts for never exposing an illegal code
   always_comb begin
      statusClean = statusIn;
      if (statusIn[`RAC_STATE_MSB:`RAC_STATE_LSB] == `RAC_STATE_RSVD) begin
         statusClean[`RAC_STATE_MSB:`RAC_STATE_LSB] =
            status_r[`RAC_STATE_MSB:`RAC_STATE_LSB];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (anyRst) begin
         status_r <= `RAC_STATUS_RST;
      end else begin
         status_r <= statusClean;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write-only cell
   always_ff @(posedge clk_sys) begin
      if (anyRst) begin
         cmdOut_r <= `RAC_CMD_RST;
         cmdPulse_r <= 1'b0;
      end else begin
         cmdPulse_r <= hit(wrEn, wrSel, `RAC_IDX_CMD);
         if (hit(wrEn, wrSel, `RAC_IDX_CMD)) begin
            cmdOut_r <= wrData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Set/clear pair; bits zero in both masks leave storage alone
   always_comb begin
      setMask = setEn ? setData : '0;
      clrMask = clrEn ? clrData : '0;
      if (hit(wrEn, wrSel, `RAC_IDX_FLAGSET)) setMask = setMask | wrData[DW-1:0];
      if (hit(wrEn, wrSel, `RAC_IDX_FLAGCLR)) clrMask = clrMask | wrData[DW-1:0];
   end

   assign sc.setMask = setMask;
   assign sc.clrMask = clrMask;
   assign sc.softRst = softRst;

   rac_setclr #(.DW(DW)) u_pair (
      .clk_sys(clk_sys),
      .rst(rst),
      .sc(sc)
   );

   assign flagsOut_r = sc.value;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; write-only and unmapped indices read zero
   always_comb begin
      flagsWide = 8'h00;
      flagsWide[DW-1:0] = sc.value;
      unique case (rdSel)
         `RAC_IDX_CTRL: rdData_nxt = ctrlOut_r;
         `RAC_IDX_STATUS: rdData_nxt = status_r;
         `RAC_IDX_FLAGSET: rdData_nxt = flagsWide;
         `RAC_IDX_FLAGCLR: rdData_nxt = flagsWide;
         `RAC_IDX_DEBUG: rdData_nxt = dbgOut_r;
         default: rdData_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdData_r <= `RAC_RDATA_RST;
      end else begin
         rdData_r <= rdData_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_ctrl_stores: assert property (hit(wrEn, wrSel, `RAC_IDX_CTRL) && !softRst |=>
      ctrlOut_r == ($past(wrData) & ~`RAC_CTRL_RSVD))
      else $error("ctrl did not store write");
   a_status_ignores: assert property (!softRst |=>
      status_r[7:2] == $past(statusIn[7:2]))
      else $error("status not from input");
   a_rsvd_zero: assert property (((ctrlOut_r & `RAC_CTRL_RSVD) == 8'h00) &&
      ((dbgOut_r & `RAC_DEBUG_RSVD) == 8'h00))
      else $error("reserved bit reads one");
   a_no_rsvd_code: assert property (status_r[`RAC_STATE_MSB:`RAC_STATE_LSB] !=
      `RAC_STATE_RSVD)
      else $error("reserved state code shown");
   a_soft_reset: assert property (softRst |=> ctrlOut_r == `RAC_CTRL_RST &&
      status_r == `RAC_STATUS_RST && flagsOut_r == '0)
      else $error("soft reset missed a cell");
   a_dbg_keeps: assert property (softRst && !hit(wrEn, wrSel, `RAC_IDX_DEBUG) |=>
      $stable(dbgOut_r))
      else $error("debug lost on soft reset");
   a_cmd_pulse: assert property (hit(wrEn, wrSel, `RAC_IDX_CMD) && !softRst |=>
      (cmdPulse_r && cmdOut_r == $past(wrData)) ##1
      (!cmdPulse_r || ($past(wrEn) && $past(wrSel) == `RAC_IDX_CMD)))
      else $error("write-only pulse wrong");
   a_alias_same: assert property ((rdSel == `RAC_IDX_FLAGSET || rdSel == `RAC_IDX_FLAGCLR)
      |=> rdData_r == rac_pkg::rac_byte_t'($past(flagsOut_r)))
      else $error("alias read mismatch");
endmodule
`default_nettype wire

// ### tb_rac_bank.sv
// Self-checking bench for the register access cell bank.
// Assumes rac_bank with DW of 8; bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module tb_rac_bank;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic softRst = 1'b0;
   logic wrEn = 1'b0;
   rac_pkg::rac_idx_t wrSel = 3'h0;
   rac_pkg::rac_byte_t wrData = 8'h00;
   logic setEn = 1'b0;
   logic [7:0] setData = 8'h00;
   logic clrEn = 1'b0;
   logic [7:0] clrData = 8'h00;
   rac_pkg::rac_byte_t statusIn = 8'h00;
   rac_pkg::rac_idx_t rdSel = 3'h0;
   rac_pkg::rac_byte_t rdData_r, ctrlOut_r, cmdOut_r, dbgOut_r;
   logic cmdPulse_r;
   logic [7:0] flagsOut_r;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;

   rac_bank #(.DW(8)) rac_bank_i (.clk_sys(clk_sys), .rst(rst), .softRst(softRst),
      .wrEn(wrEn), .wrSel(wrSel), .wrData(wrData), .setEn(setEn), .setData(setData),
      .clrEn(clrEn), .clrData(clrData), .statusIn(statusIn), .rdSel(rdSel),
      .rdData_r(rdData_r), .ctrlOut_r(ctrlOut_r), .cmdOut_r(cmdOut_r),
      .cmdPulse_r(cmdPulse_r), .dbgOut_r(dbgOut_r), .flagsOut_r(flagsOut_r));

   always #10 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (fails == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Whole run needs about 70 cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fails++;
         complete_run();
      end
   end

   task automatic chk(input string nm, input rac_pkg::rac_byte_t exp,
                      input rac_pkg::rac_byte_t got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Write is taken at the second edge; outputs checked once it settles
   // Only mapped cells are written; no fuse cells exist here
   task automatic wr(input rac_pkg::rac_idx_t idx, input rac_pkg::rac_byte_t d);
      @(posedge clk_sys);
      wrEn <= 1'b1;
      wrSel <= idx;
      wrData <= d;
      @(posedge clk_sys);
      wrEn <= 1'b0;
      #1;
   endtask

   task automatic rd(input rac_pkg::rac_idx_t idx, input rac_pkg::rac_byte_t exp);
      @(posedge clk_sys);
      rdSel <= idx;
      @(posedge clk_sys);
      #1;
      chk("rdData_r", exp, rdData_r);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      chk("ctrlOut_r", 8'h00, ctrlOut_r);
      chk("flagsOut_r", 8'h00, flagsOut_r);
      chk("dbgOut_r", 8'h00, dbgOut_r);
      chk("cmdOut_r", 8'h00, cmdOut_r);
      chk("cmdPulse_r", 8'h00, {7'h00, cmdPulse_r});
      rd(3'h0, 8'h00);
   endtask

   task automatic t_read_write();
      // Deliberate reserved-bit probe; the other ctrl write keeps them zero, t_soft_reset probes debug
      wr(3'h0, 8'hff);
      chk("ctrlOut_r", 8'h3f, ctrlOut_r);
      rd(3'h0, 8'h3f);
      wr(3'h0, 8'h12);
      rd(3'h0, 8'h12);
      rd(3'h6, 8'h00);
   endtask

   task automatic t_read_only();
      @(posedge clk_sys);
      statusIn <= 8'h05;
      rdSel <= 3'h1;
      wr(3'h1, 8'hff);
      // Read the cycle after the write, before live status could mask it
      @(posedge clk_sys);
      #1;
      chk("rdData_r", 8'h05, rdData_r);
      rd(3'h1, 8'h05);
      @(posedge clk_sys);
      statusIn <= 8'h07;
      rd(3'h1, 8'h05);
   endtask

   task automatic t_write_only();
      wr(3'h2, 8'h5a);
      chk("cmdOut_r", 8'h5a, cmdOut_r);
      chk("cmdPulse_r", 8'h01, {7'h00, cmdPulse_r});
      @(posedge clk_sys);
      #1;
      chk("cmdPulse_r", 8'h00, {7'h00, cmdPulse_r});
   endtask

   task automatic t_set_clear();
      wr(3'h3, 8'h0f);
      rd(3'h3, 8'h0f);
      rd(3'h4, 8'h0f);
      wr(3'h4, 8'h03);
      chk("flagsOut_r", 8'h0c, flagsOut_r);
      wr(3'h3, 8'h00);
      wr(3'h4, 8'h00);
      chk("flagsOut_r", 8'h0c, flagsOut_r);
      // Three masks at once; overlap must end cleared
      @(posedge clk_sys);
      wrEn <= 1'b1;
      wrSel <= 3'h3;
      wrData <= 8'h40;
      setEn <= 1'b1;
      setData <= 8'h30;
      clrEn <= 1'b1;
      clrData <= 8'h34;
      @(posedge clk_sys);
      wrEn <= 1'b0;
      setEn <= 1'b0;
      clrEn <= 1'b0;
      #1;
      chk("flagsOut_r", 8'h48, flagsOut_r);
      rd(3'h4, 8'h48);
   endtask

   task automatic t_soft_reset();
      wr(3'h5, 8'hff);
      chk("dbgOut_r", 8'h0f, dbgOut_r);
      wr(3'h2, 8'h33);
      @(posedge clk_sys);
      softRst <= 1'b1;
      @(posedge clk_sys);
      softRst <= 1'b0;
      #1;
      chk("ctrlOut_r", 8'h00, ctrlOut_r);
      chk("cmdOut_r", 8'h00, cmdOut_r);
      chk("flagsOut_r", 8'h00, flagsOut_r);
      chk("dbgOut_r", 8'h0f, dbgOut_r);
      rd(3'h5, 8'h0f);
   endtask

   // Power reset in mid-run must clear the debug cell as well
   task automatic t_power_reset();
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("dbgOut_r", 8'h00, dbgOut_r);
      chk("ctrlOut_r", 8'h00, ctrlOut_r);
      wr(3'h5, 8'h0a);
      chk("dbgOut_r", 8'h0a, dbgOut_r);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      t_reset_values();
      t_read_write();
      t_read_only();
      t_write_only();
      t_set_clear();
      t_soft_reset();
      t_power_reset();
      complete_run();
   end
endmodule
`default_nettype wire
